// File: rtl/cgt_pkg.sv
// Shared constants, types and register map of the counter gate timing generator
package cgt_pkg;
   // ==========================================================
   // Clocking
   localparam int CLK_HZ = 40_000_000;
   localparam int REF_HZ = 1_000_000;
   localparam int REF_DIV_CYC = CLK_HZ / REF_HZ;
   localparam int TICKS_PER_US = REF_HZ / 1_000_000;
   // ==========================================================
   // Times in microseconds, then in reference ticks
   localparam int PRS_FAST_US = 22_520;
   localparam int PRS_MED_US = 360_000;
   localparam int PRS_SLOW_US = 2_096_000;
   localparam int FM_PRS_US = 2_100_000;
   localparam int IF_MEAS_US = 1;
   localparam int DEAD_US = 100;
   localparam int GATE_MAX_US = 1_000_000;
   localparam int MW_MIN_US = 10;
   localparam int MS_US = 1_000;
   localparam int PRS_FAST_TICKS = PRS_FAST_US * TICKS_PER_US;
   localparam int PRS_MED_TICKS = PRS_MED_US * TICKS_PER_US;
   localparam int PRS_SLOW_TICKS = PRS_SLOW_US * TICKS_PER_US;
   localparam int FM_PRS_TICKS = FM_PRS_US * TICKS_PER_US;
   localparam int IF_TICKS = IF_MEAS_US * TICKS_PER_US;
   localparam int DEAD_TICKS = DEAD_US * TICKS_PER_US;
   localparam int GATE_MAX_TICKS = GATE_MAX_US * TICKS_PER_US;
   localparam int MW_MIN_TICKS = MW_MIN_US * TICKS_PER_US;
   localparam int MS_TICKS = MS_US * TICKS_PER_US;
   localparam int TMR_W = 24;
   // ==========================================================
   // Sequence generator
   localparam int SEQ_LEN = 20;
   localparam int SEQ_TAP = 16;
   localparam int INTERVAL_LEN = 14;
   localparam int RES_MAX = 6;
   localparam int MW_PULSES = 4;
   // ==========================================================
   // Register map (byte addresses) and status bit positions
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_COUNT = 4'h8;
   localparam int ST_BUSY = 0;
   localparam int ST_PRS_END = 1;
   localparam int ST_RUN_END = 2;
   localparam int ST_GATE_OVER = 4;
   localparam int CTRL_START = 0;
   localparam int CTRL_W = 17;
   // ==========================================================
   // Control fields
   localparam logic [1:0] SPD_FAST = 2'h0;
   localparam logic [1:0] SPD_MED = 2'h1;
   localparam logic [1:0] SPD_SLOW = 2'h2;
   localparam logic [1:0] DIAG_A = 2'h2;
   localparam logic [1:0] DIAG_B = 2'h3;
   typedef struct packed {
      logic [7:0] sample_ms;
      logic [1:0] diag;
      logic fm_tol;
      logic [1:0] acquisition_speed_select;
      logic microwave;
      logic [2:0] res;
   } ctrl_s;
   localparam ctrl_s CTRL_RST = '{8'h00, 2'h0, 1'b0, SPD_MED, 1'b0, 3'h0};
   typedef enum logic [2:0] {S_IDLE, S_IFM, S_PRS, S_GATE, S_DEAD, S_RUN} state_e;
endpackage

// File: rtl/prs_shift_register.sv
// Pseudorandom sequence shift register with clear and step inputs
`timescale 1ns/1ps
module prs_shift_register #(
   parameter int LEN = cgt_pkg::SEQ_LEN,
   parameter int TAP = cgt_pkg::SEQ_TAP
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clr,
   input wire logic step,
   output logic [LEN-1:0] q
);
   logic [LEN-1:0] q_d;
   // Inverted feedback shifts ones in from the cleared state, so it never locks up
   assign q_d = clr ? '0 : (step ? {q[LEN-2:0], ~(q[LEN-1] ^ q[TAP-1])} : q);
   always_ff @(posedge core_clk)
   begin
      if (!resetn) q <= '0;
      else q <= q_d;
   end
   a_clear_empty: assert property (@(posedge core_clk) disable iff (!resetn)
      clr |=> q == '0) else $error("shift register not cleared");
endmodule // prs_shift_register

// File: rtl/interval_counter.sv
// Loadable interval counter that pulses its terminal output every LEN ticks
`timescale 1ns/1ps
module interval_counter #(
   parameter int LEN = cgt_pkg::INTERVAL_LEN
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic tick,
   output logic term
);
   localparam int CW = $clog2(LEN + 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic last;
   assign last = tick & (cnt_q == CW'(LEN - 1));
   assign cnt_d = load ? '0 : (last ? '0 : (tick ? cnt_q + 1'b1 : cnt_q));
   // Terminal pulse on the LEN-th tick after a load, then free running
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         cnt_q <= '0;
         term <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         term <= last & ~load;
      end
   end
   a_term_count: assert property (@(posedge core_clk) disable iff (!resetn)
      term |-> $past(cnt_q) == CW'(LEN - 1)) else $error("terminal early");
endmodule // interval_counter

// File: rtl/counter_gate_timing_generator.sv
// Top of the counter gate timing generator with its Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module counter_gate_timing_generator #(
   parameter int REF_DIV = cgt_pkg::REF_DIV_CYC,
   parameter int FAST_TICKS = cgt_pkg::PRS_FAST_TICKS,
   parameter int MED_TICKS = cgt_pkg::PRS_MED_TICKS,
   parameter int SLOW_TICKS = cgt_pkg::PRS_SLOW_TICKS,
   parameter int FM_TICKS = cgt_pkg::FM_PRS_TICKS,
   parameter int MAX_GATE_TICKS = cgt_pkg::GATE_MAX_TICKS,
   parameter int CNT_W = 24
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ref_present,
   input wire logic reset_key,
   input wire logic auto_mode,
   input wire logic if_in,
   input wire logic direct_in,
   output logic counter_select_toggle,
   output logic direct_gate_n,
   output logic if_gate_n,
   output logic direct_div2,
   output logic direct_div4,
   output logic sequence_active_probe,
   output logic sequence_clock_probe,
   output logic gate_width_probe
);
   import cgt_pkg::*;

   localparam int DIV_W = $clog2(REF_DIV);

   // ==========================================================
   // Reference tick
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic tick;
   // Without the reference only a start advances, into the IF check, like the missing 1 MHz clock
   assign tick = ref_present & (div_q == DIV_W'(REF_DIV - 1));
   always_ff @(posedge core_clk)
   begin
      if (!resetn) div_q <= '0;
      else div_q <= div_d;
   end

   // ==========================================================
   // Avalon-MM slave: one wait cycle per access
   logic ack_q;
   logic req;
   logic wr_ctrl;
   logic rd_status;
   logic [31:0] rd_mux;
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_ctrl = avs_write & ack_q & (avs_address == OFS_CTRL);
   // Clear at the edge that captures the read data, so no flag set in between is lost
   assign rd_status = avs_read & ~ack_q & (avs_address == OFS_STATUS);
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         ack_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (avs_read && !ack_q) avs_readdata <= rd_mux;
      end
   end

   // ==========================================================
   // Control and sticky status registers
   ctrl_s ctrl_q;
   ctrl_s ctrl_d;
   logic prs_flag_q;
   logic run_flag_q;
   logic gate_flag_q;
   logic prs_end;
   logic run_end;
   logic gate_over;
   logic start;
   state_e st_q;
   state_e st_d;
   assign ctrl_d = wr_ctrl ? ctrl_s'(avs_writedata[CTRL_W:1]) : ctrl_q;
   // Reset key only starts a sequence in automatic mode
   assign start = (wr_ctrl & avs_writedata[CTRL_START]) | (reset_key & auto_mode);
   // Restarting the divider at start makes every interval a whole number of ticks
   assign div_d = !ref_present ? div_q :
      ((tick || (start && st_q == S_IDLE)) ? '0 : div_q + 1'b1);
   // Hardware set beats the read-to-clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         ctrl_q <= CTRL_RST;
         prs_flag_q <= 1'b0;
         run_flag_q <= 1'b0;
         gate_flag_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         prs_flag_q <= prs_end | (prs_flag_q & ~rd_status);
         run_flag_q <= run_end | (run_flag_q & ~rd_status);
         gate_flag_q <= gate_over | (gate_flag_q & ~rd_status);
      end
   end

   // ==========================================================
   // Interval lengths
   logic diag_a;
   logic [TMR_W-1:0] prs_len;
   logic [TMR_W-1:0] gate_len;
   logic [TMR_W-1:0] run_len;
   logic [TMR_W-1:0] run_raw;
   logic multi_pulse;
   assign diag_a = ctrl_q.diag == DIAG_A;

   // Decade gate width: 1 s at the coarsest resolution, divided by ten per step
   function automatic logic [TMR_W-1:0] dec_ticks(input logic [2:0] r);
      int v;
      v = MAX_GATE_TICKS;
      for (int i = 0; i < RES_MAX; i++)
      begin
         if (i >= int'(r)) v = v / 10;
      end
      return TMR_W'(v);
   endfunction

   assign prs_len = ctrl_q.fm_tol ? TMR_W'(FM_TICKS) :
      (ctrl_q.acquisition_speed_select == SPD_FAST) ? TMR_W'(FAST_TICKS) :
      (ctrl_q.acquisition_speed_select == SPD_SLOW) ? TMR_W'(SLOW_TICKS) :
      TMR_W'(MED_TICKS);
   // Microwave range at the finest resolution still needs a 10 us gate
   assign gate_len = (ctrl_q.microwave && ctrl_q.res == 3'h0) ? TMR_W'(MW_MIN_TICKS) :
      dec_ticks((ctrl_q.res > 3'(RES_MAX)) ? 3'(RES_MAX) : ctrl_q.res);
   assign multi_pulse = ctrl_q.microwave && ctrl_q.res != 3'h0 && ctrl_q.res < 3'(RES_MAX);
   // Sample-rate hold is in milliseconds; zero still holds for one tick
   assign run_raw = TMR_W'(ctrl_q.sample_ms) * TMR_W'(MS_TICKS);
   assign run_len = (run_raw == '0) ? TMR_W'(1) : run_raw;

   // ==========================================================
   // Acquisition sequencer
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] tmr_d;
   logic [1:0] pls_q;
   logic [1:0] pls_d;
   logic tmr_end;
   logic seq_clr;
   assign tmr_end = tick & (tmr_q == TMR_W'(1));
   assign prs_end = (st_q == S_PRS) & tmr_end;
   assign gate_over = (st_q == S_GATE) & tmr_end & (pls_q == 2'h0);
   assign run_end = (st_q == S_RUN) & tmr_end;
   // Shift register restarts at every sequence entry
   assign seq_clr = ((st_q == S_IFM) & tmr_end) | (prs_end & diag_a);

   // Next state: IF check, sequence, gate pulses, rundown
   always_comb
   begin
      st_d = st_q;
      pls_d = pls_q;
      tmr_d = (tick && tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
      unique case (st_q)
         S_IDLE:
            if (start)
            begin
               st_d = S_IFM;
               tmr_d = TMR_W'(IF_TICKS);
            end
         S_IFM:
            if (tmr_end)
            begin
               st_d = S_PRS;
               tmr_d = prs_len;
            end
         S_PRS:
            if (tmr_end && diag_a)
               tmr_d = prs_len;
            else if (tmr_end)
            begin
               st_d = S_GATE;
               tmr_d = gate_len;
               pls_d = multi_pulse ? 2'(MW_PULSES - 1) : 2'h0;
            end
         S_GATE:
            if (tmr_end && pls_q != 2'h0)
            begin
               st_d = S_DEAD;
               tmr_d = TMR_W'(DEAD_TICKS);
            end
            else if (tmr_end)
            begin
               st_d = S_RUN;
               tmr_d = run_len;
            end
         S_DEAD:
            if (tmr_end)
            begin
               st_d = S_GATE;
               tmr_d = gate_len;
               pls_d = pls_q - 2'h1;
            end
         S_RUN:
            if (tmr_end) st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st_q <= S_IDLE;
         tmr_q <= '0;
         pls_q <= 2'h0;
      end
      else
      begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         pls_q <= pls_d;
      end
   end

   // ==========================================================
   // Sequence generator
   logic [SEQ_LEN-1:0] seq_q;
   logic seq_step;
   interval_counter #(.LEN(INTERVAL_LEN)) u_interval (
      .core_clk(core_clk),
      .resetn(resetn),
      .load(seq_clr),
      .tick(tick),
      .term(seq_step)
   );
   prs_shift_register #(.LEN(SEQ_LEN), .TAP(SEQ_TAP)) u_prs (
      .core_clk(core_clk),
      .resetn(resetn),
      .clr(seq_clr),
      .step(seq_step),
      .q(seq_q)
   );

   // ==========================================================
   // Select and gate outputs, registered from the next state
   logic sel_d;
   logic dgate_d;
   logic igate_d;
   // Select idles low, so a dead select also blocks the IF check
   assign sel_d = (st_d == S_PRS) ? seq_q[SEQ_LEN-1] : (st_d != S_IDLE);
   // Only a gate interval with microwave off opens the direct gate
   assign dgate_d = (st_d == S_GATE) & ~ctrl_q.microwave;
   assign igate_d = (st_d == S_IFM) | ((st_d == S_GATE) & ctrl_q.microwave);
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         counter_select_toggle <= 1'b0;
         direct_gate_n <= 1'b1;
         if_gate_n <= 1'b1;
         sequence_active_probe <= 1'b0;
         gate_width_probe <= 1'b0;
         sequence_clock_probe <= 1'b0;
      end
      else
      begin
         counter_select_toggle <= sel_d;
         direct_gate_n <= ~dgate_d;
         if_gate_n <= ~igate_d;
         sequence_active_probe <= st_d == S_PRS;
         gate_width_probe <= dgate_d | ((st_d == S_GATE) & ctrl_q.microwave);
         sequence_clock_probe <= seq_step;
      end
   end

   // ==========================================================
   // Direct prescaler and counter chains
   logic in_q;
   logic if_q;
   logic d2_rise;
   logic src_a;
   logic en_a;
   logic en_b;
   logic [CNT_W-1:0] cnt_a_q;
   logic [CNT_W-1:0] cnt_b_q;
   assign d2_rise = direct_in & ~in_q & ~direct_div2;
   // Chain A sees the IF, or the direct input after the divide-by-four
   assign src_a = ctrl_q.microwave ? (if_in & ~if_q) : (d2_rise & direct_div4);
   assign en_a = ~if_gate_n | ~direct_gate_n | (diag_a & sequence_active_probe);
   // Both chains share one window in mode 2, so with microwave set their totals match within a count
   assign en_b = sequence_active_probe & ~if_gate_n | (diag_a & sequence_active_probe);
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         in_q <= 1'b0;
         if_q <= 1'b0;
         direct_div2 <= 1'b0;
         direct_div4 <= 1'b0;
      end
      else
      begin
         in_q <= direct_in;
         if_q <= if_in;
         if (direct_in && !in_q) direct_div2 <= ~direct_div2;
         if (d2_rise) direct_div4 <= ~direct_div4;
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (!resetn || seq_clr || start)
      begin
         cnt_a_q <= '0;
         cnt_b_q <= '0;
      end
      else
      begin
         if (en_a && src_a) cnt_a_q <= cnt_a_q + 1'b1;
         if (en_b && if_in && !if_q) cnt_b_q <= cnt_b_q + 1'b1;
      end
   end

   // ==========================================================
   // Read data selection
   logic [CNT_W-1:0] cnt_sel;
   assign cnt_sel = (ctrl_q.diag == DIAG_B) ? cnt_b_q : cnt_a_q;
   assign rd_mux = (avs_address == OFS_CTRL) ? 32'({ctrl_q, 1'b0}) :
      (avs_address == OFS_STATUS) ? {27'h000_0000, gate_flag_q, 1'b0, run_flag_q,
      prs_flag_q, st_q != S_IDLE} :
      (avs_address == OFS_COUNT) ? 32'(cnt_sel) : 32'h0000_0000;

   // ==========================================================
   // Checks
   sequence s_if_then_prs;
      (st_q == S_IFM) ##1 (st_q == S_PRS);
   endsequence
   a_tick_spacing: assert property (@(posedge core_clk) disable iff (!resetn)
      tick |=> !tick) else $error("reference ticks too close");
   a_ref_stop: assert property (@(posedge core_clk) disable iff (!resetn)
      !ref_present |=> $stable(st_q) || !$past(ref_present) && st_q == S_IFM)
      else $error("advanced without reference");
   a_if_select: assert property (@(posedge core_clk) disable iff (!resetn)
      st_q == S_IFM |-> counter_select_toggle && !if_gate_n)
      else $error("IF check without select");
   a_prs_active: assert property (@(posedge core_clk) disable iff (!resetn)
      s_if_then_prs |-> sequence_active_probe)
      else $error("sequence probe low");
   a_hold_high: assert property (@(posedge core_clk) disable iff (!resetn)
      st_q inside {S_GATE, S_DEAD, S_RUN} |-> counter_select_toggle)
      else $error("select toggled after sequence");
   a_direct_gate: assert property (@(posedge core_clk) disable iff (!resetn)
      !direct_gate_n |-> st_q == S_GATE && !ctrl_q.microwave)
      else $error("direct gate out of interval");
   a_gates_rest: assert property (@(posedge core_clk) disable iff (!resetn)
      st_q == S_IDLE && $past(st_q) == S_IDLE |-> direct_gate_n && if_gate_n)
      else $error("gate active while idle");
   a_gate_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      gate_over |=> gate_flag_q ##1 st_q == S_RUN || gate_flag_q)
      else $error("gate over not flagged");
   a_diag_repeat: assert property (@(posedge core_clk) disable iff (!resetn)
      prs_end && diag_a |=> st_q == S_PRS && prs_flag_q)
      else $error("mode 2 left the sequence");
   a_dead_gap: assert property (@(posedge core_clk) disable iff (!resetn)
      st_q == S_GATE && tmr_end && pls_q != 2'h0 |=> tmr_q == TMR_W'(DEAD_TICKS))
      else $error("dead time wrong");
endmodule // counter_gate_timing_generator

// File: verif/signal_source.sv
// Far-side signal source feeding the IF and direct-count inputs
`timescale 1ns/1ps
module signal_source (
   input wire logic core_clk,
   input wire logic en,
   output logic if_in,
   output logic direct_in
);
   // ==========================================
   // Stimulus edges
   // Both inputs rest low when disabled so no stray edge is counted
   always_ff @(posedge core_clk)
   begin
      if_in <= en & ~if_in;
      direct_in <= en & ~direct_in;
   end
endmodule // signal_source

// File: verif/tb_counter_gate_timing_generator.sv
// Self-checking bench of the counter gate timing generator
`timescale 1ns/1ps
module tb_counter_gate_timing_generator;
   import cgt_pkg::*;
   localparam int RD = 2;
   logic core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic reset_key = 0, auto_mode = 0, en = 0, if_in, direct_in, sel, dg_n, ig_n;
   logic d2, d4, pa, pc, pw, dg_q, ig_q, d2_q, d4_q, di_q;
   int failures = 0, n_compared = 0, dlow, dfall, ilow, ifall, plen, selbad, n2, n4, ndi;
   int plw, npc;
   counter_gate_timing_generator #(.REF_DIV(RD), .FAST_TICKS(30), .MED_TICKS(40),
      .SLOW_TICKS(50), .FM_TICKS(60)) u_counter_gate_timing_generator (.core_clk(core_clk),
      .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ref_present(1'b1), .reset_key(reset_key),
      .auto_mode(auto_mode), .if_in(if_in), .direct_in(direct_in),
      .counter_select_toggle(sel), .direct_gate_n(dg_n), .if_gate_n(ig_n), .direct_div2(d2),
      .direct_div4(d4), .sequence_active_probe(pa), .sequence_clock_probe(pc),
      .gate_width_probe(pw));
   signal_source u_signal_source (.core_clk(core_clk), .en(en), .if_in(if_in),
      .direct_in(direct_in));
   // ==========================================
   // Clock
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   // ==========================================
   // Output monitor, cleared by reset so edges line up with the design
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         {dlow, dfall, ilow, ifall, plen, selbad, n2, n4, ndi, plw, npc} = '0;
      end
      else
      begin
         dlow += int'(dg_n === 1'b0);
         dfall += int'(dg_q && dg_n === 1'b0);
         ilow += int'(ig_n === 1'b0);
         ifall += int'(ig_q && ig_n === 1'b0);
         plen += int'(pa === 1'b1);
         selbad += int'((ig_n === 1'b0 || dg_n === 1'b0) && sel !== 1'b1);
         plw += int'(pw === 1'b1);
         npc += int'(pc === 1'b1);
         n2 += int'(!d2_q && d2 === 1'b1);
         n4 += int'(!d4_q && d4 === 1'b1);
         ndi += int'(!di_q && direct_in === 1'b1);
      end
      {dg_q, ig_q, d2_q, d4_q, di_q} = {dg_n, ig_n, d2, d4, direct_in};
   end
   // ==========================================
   // Common tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      i = 0;
      do
      begin
         @(posedge core_clk);
         i++;
      end
      while (avs_waitrequest !== 1'b0 && i < 50);
      if (i >= 50)
      begin
         failures++;
         finish_test();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Let one edge pass so a following call never re-raises in the same step
      @(posedge core_clk);
   endtask
   task automatic rst();
      resetn <= 1'b0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
   endtask
   // Polls status until busy drops, gathering the sticky flags
   task automatic run(input logic [31:0] c, input logic key, input int prs, input int dl,
      input int df, input int il, input int ifl);
      logic [31:0] acc;
      int i;
      acc = '0;
      bus(1'b1, OFS_CTRL, c | 32'(!key));
      if (key)
      begin
         reset_key <= 1'b1;
         @(posedge core_clk);
         reset_key <= 1'b0;
      end
      for (i = 0; i < 3000; i++)
      begin
         bus(1'b0, OFS_STATUS, 32'h0);
         acc |= q;
         if (i > 1 && q[ST_BUSY] === 1'b0)
            break;
      end
      check(32'(i < 3000), 1);
      check(acc & 32'h0000_0016, 32'h0000_0016);
      check(plen, prs * RD);
      check(dlow, dl * RD);
      check(dfall, df);
      check(ilow, il * RD);
      check(ifall, ifl);
      check(selbad, 0);
      check(plw, (dl + il - 1) * RD);
      rst();
   endtask
   function automatic logic [31:0] mk(int res, int mw, logic [1:0] spd, int fm);
      return 32'((res << 1) | (mw << 4) | (spd << 5) | (fm << 7));
   endfunction
   // ==========================================
   // Scenarios
   task automatic reset_values();
      check({sel, dg_n, ig_n, pa}, 4'h6);
      bus(1'b0, OFS_CTRL, 32'h0);
      check(q, 32'h0000_0020);
      bus(1'b0, 4'hc, 32'h0);
      check(q, 32'h0000_0000);
   endtask
   task automatic regenerate();
      int i;
      int n;
      n = 0;
      en <= 1'b1;
      bus(1'b1, OFS_CTRL, mk(0, 0, SPD_MED, 0) | 32'h0000_0201);
      for (i = 0; i < 2000 && n < 2; i++)
      begin
         bus(1'b0, OFS_STATUS, 32'h0);
         n += int'(q[ST_PRS_END] === 1'b1);
      end
      check(n, 2);
      check(pa, 1'b1);
      check(32'(npc > 0), 1);
      // Well inside the next loop, so chain A has counted since its last clear
      repeat (40) @(posedge core_clk);
      bus(1'b0, OFS_COUNT, 32'h0);
      check(32'(q != 0), 1);
      en <= 1'b0;
      rst();
   endtask
   task automatic dividers();
      en <= 1'b1;
      repeat (40) @(posedge core_clk);
      en <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(n2, (ndi + 1) / 2);
      check(n4, (ndi + 3) / 4);
   endtask
   initial
   begin
      rst();
      reset_values();
      run(mk(0, 0, SPD_MED, 0), 1'b0, 40, 1, 1, 1, 1);
      run(mk(2, 0, SPD_FAST, 0), 1'b0, 30, 100, 1, 1, 1);
      run(mk(0, 1, SPD_SLOW, 0), 1'b0, 50, 0, 0, 11, 2);
      run(mk(1, 1, SPD_MED, 0), 1'b0, 40, 0, 0, 41, 5);
      auto_mode <= 1'b1;
      run(mk(0, 0, SPD_FAST, 1), 1'b1, 60, 1, 1, 1, 1);
      regenerate();
      dividers();
      finish_test();
   end
endmodule // tb_counter_gate_timing_generator
